/* File: dv/amgw_conv_model.sv */
`timescale 1ns/100ps
`default_nettype none
module amgw_conv_model
  import amgw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        conv_power,
  input  wire logic        conv_start,
  input  wire logic [11:0] sample,
  input  wire logic [7:0]  latency,
  output var  logic        conv_done,
  output var  logic [11:0] conv_data
);
  // ==========================================================
  // Converter core: converts only while powered, aborts on power loss
  logic [7:0] cnt_reg;
  logic       run_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg   <= 8'h00;
      run_reg   <= 1'b0;
      conv_done <= 1'b0;
      conv_data <= 12'h000;
    end
    else
    begin
      conv_done <= 1'b0;
      // Data is only valid with the done pulse; toggle so stale values never match
      conv_data <= ~conv_data;
      if (conv_start && conv_power)
      begin
        run_reg <= 1'b1;
        cnt_reg <= latency;
      end
      else if (!conv_power)
        run_reg <= 1'b0;
      else if (run_reg && cnt_reg == 8'h00)
      begin
        run_reg   <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= sample;
      end
      else if (run_reg)
        cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule // amgw_conv_model
`default_nettype wire

/* File: dv/test_amgw_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module test_amgw_ctrl
  import amgw_pkg::*;
;
  // ==========================================================
  // Signals
  logic             clk;
  logic             arst_n;
  amgw_sfr_s        sfr_req;
  logic [7:0]       sfr_rdata;
  logic             conv_done;
  logic [11:0]      conv_data;
  logic [11:0]      sample;
  logic [7:0]       latency;
  logic             conv_power;
  logic             conv_start;
  logic [MUX_W-1:0] input_selector;
  logic [12:0]      gain_code;
  logic             window_hit_flag;
  logic             conv_busy;
  int               miscompares;
  int               checks_done;
  int               n_starts;
  int               gap;
  int               min_gap;

  amgw_ctrl amgw_ctrl_i (.clk(clk), .arst_n(arst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .conv_done(conv_done), .conv_data(conv_data), .conv_power(conv_power), .conv_start(conv_start),
    .input_selector(input_selector), .gain_code(gain_code), .window_hit_flag(window_hit_flag),
    .conv_busy(conv_busy));

  amgw_conv_model amgw_conv_model_i (.clk(clk), .arst_n(arst_n), .conv_power(conv_power),
    .conv_start(conv_start), .sample(sample), .latency(latency), .conv_done(conv_done),
    .conv_data(conv_data));

  always #20 clk = ~clk;

  // ==========================================================
  // Common tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1 sfr_req = '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1 sfr_req = '0;
    d = sfr_rdata;
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (conv_busy !== 1'b0 && k < 4000)
    begin
      @(posedge clk);
      #1 k++;
    end
    if (k >= 4000)
      check(32'h0, 32'h1, "conversion never finished");
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Start spacing and power at every start
  always @(posedge clk)
  begin
    gap++;
    if (conv_start === 1'b1)
    begin
      check(conv_power, 1'b1, "start while unpowered");
      n_starts++;
      if (gap < min_gap)
        min_gap = gap;
      gap = 0;
    end
  end

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] ra [10] = '{ADDR_CTRL, ADDR_CFG, ADDR_CHAN, ADDR_GAIN_H, ADDR_GAIN_L, ADDR_GAIN_A,
      ADDR_UPR_H, ADDR_UPR_L, ADDR_LWR_H, 8'h80};
    logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h1F, 8'hFC, 8'h00, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00};
    logic [7:0] d;
    check(gain_code, 13'h1000, "unity gain after reset");
    check(conv_power, 1'b0, "powered after reset");
    check(input_selector, 19'h4_0000, "selector after reset");
    for (int i = 0; i < 10; i++)
    begin
      rd(ra[i], d);
      check(d, rv[i], "register reset value");
    end
  endtask

  task automatic t_chan;
    logic [MUX_W-1:0] e;
    logic [7:0]       d;
    for (int c = 0; c < 32; c++)
    begin
      wr(ADDR_CHAN, {3'b111, c[4:0]});
      @(posedge clk);
      #1 e = '0;
      if (c < 16)
        e[c] = 1'b1;
      else if (c == 24)
        e[16] = 1'b1;
      else if (c == 25)
        e[17] = 1'b1;
      else
        e[18] = 1'b1;
      check(input_selector, e, "channel routing");
      rd(ADDR_CHAN, d);
      check(d, {3'b000, c[4:0]}, "channel readback");
    end
  endtask

  task automatic t_gain;
    logic [7:0] gh [5] = '{8'hFC, 8'h7C, 8'hBC, 8'hFF, 8'hFF};
    logic [7:0] gl [5] = '{8'h00, 8'h00, 8'h00, 8'hF0, 8'hFF};
    logic       ga [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 5; i++)
    begin
      wr(ADDR_GAIN_H, gh[i]);
      wr(ADDR_GAIN_L, gl[i]);
      wr(ADDR_GAIN_A, {7'h00, ga[i]});
      repeat (2) @(posedge clk);
      #1 check(gain_code, {1'b0, gh[i], gl[i][7:4]} + (ga[i] ? 13'h0040 : 13'h0000), "gain");
    end
  endtask

  // One enabled conversion, then window flag and result readback
  task automatic t_conv(input logic [15:0] up, input logic [15:0] lo, input logic [11:0] s,
                        input logic flag, input logic [15:0] res);
    logic [7:0] h;
    logic [7:0] l;
    wr(ADDR_UPR_H, up[15:8]);
    wr(ADDR_UPR_L, up[7:0]);
    wr(ADDR_LWR_H, lo[15:8]);
    wr(ADDR_LWR_L, lo[7:0]);
    sample = s;
    latency = 8'h03;
    wr(ADDR_CTRL, 8'h90);
    check(conv_power, 1'b1, "enable powers converter");
    wait_idle();
    check(window_hit_flag, flag, "window flag");
    rd(ADDR_RES_H, h);
    rd(ADDR_RES_L, l);
    check({h, l}, res, "result");
  endtask

  task automatic t_window;
    logic [15:0] up [9] = '{16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0200, 16'h0200, 16'h0200,
      16'h0200, 16'h0300};
    logic [15:0] lo [9] = '{16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0100, 16'h0100, 16'h0100,
      16'h0100, 16'h0300};
    logic [11:0] s [9] = '{12'h100, 12'h101, 12'h1FF, 12'h200, 12'h0FF, 12'h100, 12'h200, 12'h201, 12'h301};
    logic        f [9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 9; i++)
      t_conv(up[i], lo[i], s[i], f[i], {4'h0, s[i]});
    wr(ADDR_CTRL, 8'h00);
    @(posedge clk);
    #1 check(conv_power, 1'b0, "disabled converter shut down");
  endtask

  // Burst of four slow conversions with enable low
  task automatic t_burst;
    logic [7:0] h;
    logic [7:0] l;
    wr(ADDR_CFG, 8'h01);
    sample = 12'h123;
    latency = 8'd100;
    n_starts = 0;
    min_gap = 100000;
    wr(ADDR_CTRL, 8'h50);
    check(conv_power, 1'b1, "burst powers converter");
    wait_idle();
    check(n_starts, 4, "burst sample count");
    check(min_gap >= 125, 1'b1, "start spacing");
    check(conv_power, 1'b0, "burst returns to shutdown");
    rd(ADDR_CTRL, h);
    check(h, 8'h68, "control flags after burst");
    rd(ADDR_RES_H, h);
    rd(ADDR_RES_L, l);
    check({h, l}, 16'h048C, "accumulated sum");
  endtask

  task automatic t_ljust;
    logic [7:0] h;
    wr(ADDR_CFG, 8'h04);
    t_conv(16'hAB00, 16'hAC00, 12'hABC, 1'b1, 16'hABC0);
    // Result registers are read-only
    wr(ADDR_RES_H, 8'h55);
    rd(ADDR_RES_H, h);
    check(h, 8'hAB, "result not writable");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    sfr_req = '0;
    sample = 12'h000;
    latency = 8'h03;
    miscompares = 0;
    checks_done = 0;
    n_starts = 0;
    gap = 0;
    min_gap = 100000;
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    t_reset();
    t_chan();
    t_gain();
    t_window();
    t_burst();
    t_ljust();
    give_verdict();
  end

  initial
  begin
    #(20000 * 40);
    miscompares++;
    give_verdict();
  end
endmodule // test_amgw_ctrl
`default_nettype wire

/* File: hw/amgw_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module amgw_ctrl
  import amgw_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire amgw_sfr_s        sfr_req,
  output var  logic [7:0]       sfr_rdata,
  input  wire logic             conv_done,
  input  wire logic [11:0]      conv_data,
  output var  logic             conv_power,
  output var  logic             conv_start,
  output var  logic [MUX_W-1:0] input_selector,
  output var  logic [12:0]      gain_code,
  output var  logic             window_hit_flag,
  output var  logic             conv_busy
);

  amgw_st_s    st_reg;
  amgw_st_s    st_next;
  logic [15:0] acc_sum;
  logic [15:0] fin_res;
  logic        finishing;
  logic        win_hit;
  logic        start_req;
  logic [12:0] gain_applied;

  // ==========================================================
  // Datapath helpers
  assign acc_sum   = st_reg.acc + {4'h0, conv_data};
  assign fin_res   = justify(acc_sum, st_reg.ljust);
  assign finishing = (st_reg.fsm == ST_CONV) && conv_done && (st_reg.left == 5'h01);

  amgw_gain u_gain (
    .gain_high_byte        (st_reg.gain_h),
    .gain_low_nibble       (st_reg.gain_l),
    .extra_sixtyfourth_bit (st_reg.gain_add),
    .gain_word             (),
    .gain_applied          (gain_applied)
  );

  // Limits are raw register contents, so they follow the result's justification
  amgw_window u_window (
    .result    (fin_res),
    .upper_cmp (st_reg.upr),
    .lower_cmp (st_reg.lwr),
    .eval      (finishing),
    .hit       (win_hit)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    start_req = 1'b0;
    st_next.start_p = 1'b0;
    if (st_reg.per != 8'h00)
      st_next.per = st_reg.per - 8'h01;

    // Register writes; software may also write flags to one
    if (sfr_req.wr)
    begin
      if (sfr_req.addr == ADDR_CTRL)
      begin
        st_next.en        = sfr_req.wdata[CTRL_EN];
        st_next.burst     = sfr_req.wdata[CTRL_BURST];
        st_next.done_flag = sfr_req.wdata[CTRL_DONE];
        st_next.win_flag  = sfr_req.wdata[CTRL_WIN];
        start_req         = sfr_req.wdata[CTRL_BUSY];
      end
      else if (sfr_req.addr == ADDR_CFG)
      begin
        st_next.ljust = sfr_req.wdata[CFG_LJUST];
        st_next.rpt   = sfr_req.wdata[1:0];
      end
      else if (sfr_req.addr == ADDR_CHAN)
        st_next.chan = sfr_req.wdata[4:0];
      else if (sfr_req.addr == ADDR_GAIN_H)
        st_next.gain_h = sfr_req.wdata;
      else if (sfr_req.addr == ADDR_GAIN_L)
        st_next.gain_l = sfr_req.wdata;
      else if (sfr_req.addr == ADDR_GAIN_A)
        st_next.gain_add = sfr_req.wdata[0];
      else if (sfr_req.addr == ADDR_UPR_H)
        st_next.upr[15:8] = sfr_req.wdata;
      else if (sfr_req.addr == ADDR_UPR_L)
        st_next.upr[7:0] = sfr_req.wdata;
      else if (sfr_req.addr == ADDR_LWR_H)
        st_next.lwr[15:8] = sfr_req.wdata;
      else if (sfr_req.addr == ADDR_LWR_L)
        st_next.lwr[7:0] = sfr_req.wdata;
    end

    // Sequencer
    case (st_reg.fsm)
      ST_IDLE:
      begin
        if (start_req)
        begin
          st_next.acc  = 16'h0000;
          st_next.left = samples(st_next.rpt);
          if (st_next.burst)
          begin
            // Burst powers the core itself and waits for it to settle
            st_next.burst_act = 1'b1;
            st_next.tmr = 8'(WARM_CYC - 1);
            st_next.fsm = ST_WARM;
          end
          else if (st_next.en)
            st_next.fsm = ST_GAP;
        end
      end
      ST_WARM:
      begin
        if (st_reg.tmr == 8'h00)
          st_next.fsm = ST_GAP;
        else
          st_next.tmr = st_reg.tmr - 8'h01;
      end
      ST_GAP:
      begin
        // Starts are spaced a full sample period apart
        if (st_reg.per == 8'h00)
        begin
          st_next.start_p = 1'b1;
          st_next.per = 8'(CONV_CYC - 1);
          st_next.fsm = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (conv_done)
        begin
          st_next.acc = acc_sum;
          if (st_reg.left == 5'h01)
          begin
            st_next.result    = fin_res;
            st_next.done_flag = 1'b1;
            st_next.burst_act = 1'b0;
            st_next.fsm       = ST_IDLE;
          end
          else
          begin
            st_next.left = st_reg.left - 5'h01;
            st_next.fsm  = ST_GAP;
          end
        end
      end
      default:
        st_next.fsm = ST_IDLE;
    endcase

    // Hardware set wins over a same-cycle software clear
    if (win_hit)
      st_next.win_flag = 1'b1;

    // Clearing enable outside a burst abandons a pending conversion
    if (!st_next.en && !st_reg.burst_act && st_reg.fsm != ST_IDLE && !finishing)
    begin
      // A start launched into a core that is losing power would be lost anyway
      st_next.fsm     = ST_IDLE;
      st_next.start_p = 1'b0;
    end
    st_next.busy   = st_next.fsm != ST_IDLE;

    st_next.power  = st_next.en | st_next.burst_act;
    st_next.mux    = chan_decode(st_next.chan);
    st_next.gain_q = gain_applied;

    // Read port answers one cycle after the strobe
    if (sfr_req.rd)
    begin
      if (sfr_req.addr == ADDR_CTRL)
        st_next.rdata = {st_reg.en, st_reg.burst, st_reg.done_flag, st_reg.fsm != ST_IDLE,
                         st_reg.win_flag, 3'h0};
      else if (sfr_req.addr == ADDR_CFG)
        st_next.rdata = {5'h00, st_reg.ljust, st_reg.rpt};
      else if (sfr_req.addr == ADDR_CHAN)
        st_next.rdata = {3'h0, st_reg.chan};
      else if (sfr_req.addr == ADDR_RES_H)
        st_next.rdata = st_reg.result[15:8];
      else if (sfr_req.addr == ADDR_RES_L)
        st_next.rdata = st_reg.result[7:0];
      else if (sfr_req.addr == ADDR_GAIN_H)
        st_next.rdata = st_reg.gain_h;
      else if (sfr_req.addr == ADDR_GAIN_L)
        st_next.rdata = st_reg.gain_l;
      else if (sfr_req.addr == ADDR_GAIN_A)
        st_next.rdata = {7'h00, st_reg.gain_add};
      else if (sfr_req.addr == ADDR_UPR_H)
        st_next.rdata = st_reg.upr[15:8];
      else if (sfr_req.addr == ADDR_UPR_L)
        st_next.rdata = st_reg.upr[7:0];
      else if (sfr_req.addr == ADDR_LWR_H)
        st_next.rdata = st_reg.lwr[15:8];
      else if (sfr_req.addr == ADDR_LWR_L)
        st_next.rdata = st_reg.lwr[7:0];
      else
        st_next.rdata = 8'h00;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= ST_RST;
    else
      st_reg <= st_next;
  end

  assign sfr_rdata       = st_reg.rdata;
  assign conv_power      = st_reg.power;
  assign conv_start      = st_reg.start_p;
  assign input_selector  = st_reg.mux;
  assign gain_code       = st_reg.gain_q;
  assign window_hit_flag = st_reg.win_flag;
  assign conv_busy       = st_reg.busy;

  // ==========================================================
  // Checks
  shutdown_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!st_reg.en && !st_reg.burst_act) |-> !conv_power)
    else $error("converter powered while disabled and idle");

  burst_power_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg.fsm == ST_IDLE && $past(st_reg.fsm) == ST_CONV && st_reg.burst_act == 1'b0
     && !st_reg.en) |-> !conv_power)
    else $error("burst did not return converter to shutdown");

  warm_power_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg.fsm == ST_WARM) |-> conv_power throughout ##1 (st_reg.fsm != ST_IDLE))
    else $error("converter not powered during burst warm-up");

  port_route_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg.chan <= CH_LAST_PORT) |-> input_selector[st_reg.chan[3:0]] && $onehot(input_selector))
    else $error("port channel not routed");

  special_route_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg.chan > CH_LAST_PORT) |-> (st_reg.chan == CH_TEMP ? input_selector[MUX_TEMP] :
      st_reg.chan == CH_VDD ? input_selector[MUX_VDD] : input_selector[MUX_GND]))
    else $error("special channel not routed");

  gain_value_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 (gain_code == {1'b0, $past(st_reg.gain_h), $past(st_reg.gain_l[7:4])}
         + ($past(st_reg.gain_add) ? 13'h0040 : 13'h0000)))
    else $error("applied gain does not match registers");

  inside_hit_a: assert property (@(posedge clk) disable iff (!arst_n)
    (finishing && st_reg.lwr > st_reg.upr && fin_res > st_reg.upr && fin_res < st_reg.lwr)
    |=> window_hit_flag && st_reg.result == $past(fin_res))
    else $error("inside window hit not flagged");

  outside_hit_a: assert property (@(posedge clk) disable iff (!arst_n)
    (finishing && st_reg.lwr <= st_reg.upr && (fin_res < st_reg.lwr || fin_res > st_reg.upr))
    |=> window_hit_flag)
    else $error("outside window hit not flagged");

  no_false_hit_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!finishing && !window_hit_flag && !(sfr_req.wr && sfr_req.addr == ADDR_CTRL
     && sfr_req.wdata[CTRL_WIN])) |=> !window_hit_flag)
    else $error("window flag set without a completed conversion");

  start_space_a: assert property (@(posedge clk) disable iff (!arst_n)
    conv_start |=> !conv_start [*8] ##0 (st_reg.per == 8'(CONV_CYC - 9)))
    else $error("conversion starts closer than one sample period");

  // ==========================================================
  // Register port checks
  gain_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    (sfr_req.rd && sfr_req.addr == ADDR_GAIN_H) |=> (sfr_rdata == $past(st_reg.gain_h)))
    else $error("gain high byte read back wrong");

  limit_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    (sfr_req.rd && sfr_req.addr == ADDR_UPR_H) |=> (sfr_rdata == $past(st_reg.upr[15:8])))
    else $error("limit high byte read back wrong");

  result_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    (sfr_req.rd && sfr_req.addr == ADDR_RES_L) |=> (sfr_rdata == $past(st_reg.result[7:0])))
    else $error("result low byte read back wrong");

  ctrl_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    (sfr_req.rd && sfr_req.addr == ADDR_CTRL) |=> (sfr_rdata[CTRL_WIN] == $past(st_reg.win_flag)))
    else $error("window flag read back wrong");

  limit_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (sfr_req.wr && sfr_req.addr == ADDR_LWR_L) |=> (st_reg.lwr[7:0] == $past(sfr_req.wdata)
      && st_reg.lwr[15:8] == $past(st_reg.lwr[15:8])))
    else $error("limit byte write disturbed its pair");

  gain_extra_a: assert property (@(posedge clk) disable iff (!arst_n)
    (sfr_req.wr && sfr_req.addr == ADDR_GAIN_A) |=> (st_reg.gain_add == $past(sfr_req.wdata[0])))
    else $error("extra gain bit not written");

  chan_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (sfr_req.wr && sfr_req.addr == ADDR_CHAN) |=> (st_reg.chan == $past(sfr_req.wdata[4:0])))
    else $error("channel code not written");

  mux_onehot_a: assert property (@(posedge clk) disable iff (!arst_n)
    $onehot(input_selector))
    else $error("input selector not one-hot");

  // ==========================================================
  // Sequencer checks
  enable_power_a: assert property (@(posedge clk) disable iff (!arst_n)
    st_reg.en |-> conv_power)
    else $error("enabled converter not powered");

  start_powered_a: assert property (@(posedge clk) disable iff (!arst_n)
    conv_start |-> conv_power)
    else $error("start issued to unpowered converter");

  burst_start_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg.fsm == ST_IDLE && sfr_req.wr && sfr_req.addr == ADDR_CTRL && sfr_req.wdata[CTRL_BUSY]
     && sfr_req.wdata[CTRL_BURST]) |=> (st_reg.fsm == ST_WARM && conv_power))
    else $error("burst did not power up the converter");

  warm_length_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg.fsm == ST_WARM && st_reg.tmr == 8'h00) |=> (st_reg.fsm == ST_GAP))
    else $error("warm-up did not end on time");

  gap_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg.fsm == ST_GAP && st_reg.per != 8'h00) |=> !conv_start)
    else $error("start issued before sample period elapsed");

  burst_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg.burst_act && st_reg.fsm == ST_CONV && conv_done && st_reg.left != 5'h01)
    |=> (st_reg.fsm == ST_GAP && st_reg.left == $past(st_reg.left) - 5'h01))
    else $error("burst sample count not advanced");

  finish_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
    finishing |=> (st_reg.done_flag && !conv_busy))
    else $error("finished sequence not flagged done");

  result_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !finishing |=> $stable(st_reg.result))
    else $error("result changed without a finished conversion");

endmodule // amgw_ctrl
`default_nettype wire

/* File: hw/amgw_gain.sv */
`timescale 1ns/100ps
`default_nettype none
module amgw_gain
  import amgw_pkg::*;
(
  input  wire logic [7:0]  gain_high_byte,
  input  wire logic [7:0]  gain_low_nibble,
  input  wire logic        extra_sixtyfourth_bit,
  output var  logic [11:0] gain_word,
  output var  logic [12:0] gain_applied
);

  // ==========================================================
  // Gain in units of 1/4096; the low register's low nibble is ignored
  assign gain_word    = {gain_high_byte, gain_low_nibble[7:4]};
  assign gain_applied = {1'b0, gain_word} + (extra_sixtyfourth_bit ? GAIN_SIXTYFOURTH : 13'h0000);

endmodule // amgw_gain
`default_nettype wire

/* File: hw/amgw_window.sv */
`timescale 1ns/100ps
`default_nettype none
module amgw_window
  import amgw_pkg::*;
(
  input  wire logic [15:0] result,
  input  wire logic [15:0] upper_cmp,
  input  wire logic [15:0] lower_cmp,
  input  wire logic        eval,
  output var  logic        hit
);

  logic inside_mode;

  // ==========================================================
  // No mode bit: the ordering of the two limits picks the sense
  assign inside_mode = lower_cmp > upper_cmp;
  assign hit = eval & (inside_mode ? (result > upper_cmp && result < lower_cmp)
                                   : (result < lower_cmp || result > upper_cmp));

endmodule // amgw_window
`default_nettype wire

/* File: include/amgw_pkg.sv */
package amgw_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL   = 8'hE8;
  localparam logic [7:0] ADDR_CFG    = 8'hBC;
  localparam logic [7:0] ADDR_CHAN   = 8'hBB;
  localparam logic [7:0] ADDR_RES_H  = 8'hBE;
  localparam logic [7:0] ADDR_RES_L  = 8'hBD;
  localparam logic [7:0] ADDR_UPR_H  = 8'hC4;
  localparam logic [7:0] ADDR_UPR_L  = 8'hC3;
  localparam logic [7:0] ADDR_LWR_H  = 8'hC6;
  localparam logic [7:0] ADDR_LWR_L  = 8'hC5;
  localparam logic [7:0] ADDR_GAIN_H = 8'hCA;
  localparam logic [7:0] ADDR_GAIN_L = 8'hCB;
  localparam logic [7:0] ADDR_GAIN_A = 8'hCC;

  // ==========================================================
  // Field positions
  localparam int CTRL_EN    = 7;
  localparam int CTRL_BURST = 6;
  localparam int CTRL_DONE  = 5;
  localparam int CTRL_BUSY  = 4;
  localparam int CTRL_WIN   = 3;
  localparam int CFG_LJUST  = 2;
  localparam int MUX_TEMP   = 16;
  localparam int MUX_VDD    = 17;
  localparam int MUX_GND    = 18;
  localparam int MUX_W      = 19;

  // ==========================================================
  // Codes and reset values
  localparam logic [4:0]  CH_LAST_PORT = 5'h0F;
  localparam logic [4:0]  CH_TEMP      = 5'h18;
  localparam logic [4:0]  CH_VDD       = 5'h19;
  localparam logic [4:0]  CHAN_RST     = 5'h1F;
  localparam logic [7:0]  GAIN_H_RST   = 8'hFC;
  localparam logic [7:0]  GAIN_L_RST   = 8'h00;
  localparam logic        GAIN_A_RST   = 1'b1;
  localparam logic [12:0] GAIN_SIXTYFOURTH = 13'h0040;
  localparam logic [12:0] GAIN_Q_RST   = 13'h1000;
  localparam logic [15:0] UPR_RST      = 16'hFFFF;
  localparam logic [15:0] LWR_RST      = 16'h0000;

  // ==========================================================
  // Timing
  localparam int CLK_HZ     = 25_000_000;
  localparam int CLK_NS     = 40;
  localparam int MAX_SPS    = 200_000;
  localparam int WARM_NS    = 1500;
  localparam int CONV_CYC   = (CLK_HZ + MAX_SPS - 1) / MAX_SPS;
  localparam int WARM_CYC   = (WARM_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE, ST_WARM, ST_GAP, ST_CONV} amgw_fsm_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } amgw_sfr_s;

  typedef struct packed {
    amgw_fsm_e        fsm;
    logic             en;
    logic             burst;
    logic             ljust;
    logic [1:0]       rpt;
    logic             done_flag;
    logic             win_flag;
    logic             burst_act;
    logic [4:0]       chan;
    logic [7:0]       gain_h;
    logic [7:0]       gain_l;
    logic             gain_add;
    logic [15:0]      upr;
    logic [15:0]      lwr;
    logic [15:0]      result;
    logic [15:0]      acc;
    logic [4:0]       left;
    logic [7:0]       tmr;
    logic [7:0]       per;
    logic             start_p;
    logic             power;
    logic             busy;
    logic [MUX_W-1:0] mux;
    logic [12:0]      gain_q;
    logic [7:0]       rdata;
  } amgw_st_s;

  localparam amgw_st_s ST_RST = '{fsm: ST_IDLE, en: 1'b0, burst: 1'b0, ljust: 1'b0, rpt: 2'h0,
    done_flag: 1'b0, win_flag: 1'b0, burst_act: 1'b0, chan: CHAN_RST, gain_h: GAIN_H_RST,
    gain_l: GAIN_L_RST, gain_add: GAIN_A_RST, upr: UPR_RST, lwr: LWR_RST, result: 16'h0000,
    acc: 16'h0000, left: 5'h00, tmr: 8'h00, per: 8'h00, start_p: 1'b0, power: 1'b0, busy: 1'b0,
    mux: 19'h4_0000, gain_q: GAIN_Q_RST, rdata: 8'h00};

  // ==========================================================
  // Helpers
  function automatic logic [MUX_W-1:0] chan_decode(input logic [4:0] code);
    logic [MUX_W-1:0] sel;
    sel = '0;
    if (code <= CH_LAST_PORT) sel[code[3:0]] = 1'b1;
    else if (code == CH_TEMP) sel[MUX_TEMP] = 1'b1;
    else if (code == CH_VDD) sel[MUX_VDD] = 1'b1;
    else sel[MUX_GND] = 1'b1;
    return sel;
  endfunction

  function automatic logic [4:0] samples(input logic [1:0] rpt);
    case (rpt)
      2'h0:    return 5'h01;
      2'h1:    return 5'h04;
      2'h2:    return 5'h08;
      default: return 5'h10;
    endcase
  endfunction

  function automatic logic [15:0] justify(input logic [15:0] sum, input logic left_j);
    return left_j ? {sum[11:0], 4'h0} : sum;
  endfunction

endpackage
